// ==== logic/i2c_slave_pkg.sv ====
// Constants, types and register map of the two-wire serial slave
// ======================================================================
package i2c_slave_pkg;

    // ==================================================================
    // Register map
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] OWN_ADDR_OFFSET = 4'h1;
    localparam logic [3:0] DATA_OFFSET = 4'h2;
    localparam logic [3:0] STATUS_OFFSET = 4'h3;
    localparam logic [3:0] INT_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] INT_MASK_OFFSET = 4'h5;
    localparam logic [3:0] BUF_INDEX_OFFSET = 4'h6;
    localparam logic [3:0] BUF_DATA_OFFSET = 4'h7;
    localparam logic [3:0] BUF_PTR_OFFSET = 4'h8;

    // ==================================================================
    // Reset values
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
    localparam logic [4:0] INT_MASK_RESET = 5'h00;

    // ==================================================================
    // Interrupt event bit positions and event count
    localparam int EV_ADDR = 0;
    localparam int EV_RX = 1;
    localparam int EV_TX = 2;
    localparam int EV_STOP = 3;
    localparam int EV_START = 4;
    localparam int EV_W = 5;

    // ==================================================================
    // Buffer geometry
    localparam int BUF_DEPTH = 32;
    localparam int BUF_PTR_W = 5;

    // ==================================================================
    // Timing
    localparam int CLOCK_KHZ = 10000;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_MIN_PERIOD_CYCLES = CLOCK_KHZ / SCL_MAX_KHZ;
    localparam int TSU_DAT_NS = 250;
    localparam logic [3:0] SETUP_CYCLES =
        4'((TSU_DAT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    // ==================================================================
    // Types
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_type;

    typedef struct packed {
        logic nack;
        logic monitor_en;
        logic ram_buffer_mode;
        logic hw_match_en;
        logic enable;
    } ctrl_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RX,
        ST_ACK_OUT,
        ST_TX,
        ST_ACK_IN
    } state_type;

endpackage

// ==== logic/i2c_slave_enhanced.sv ====
// Two-wire serial slave with legacy stalling and RAM buffer schemes
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_enhanced
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Register port
    input wire i2c_slave_pkg::reg_req_type bus_req_i,
    output logic [7:0] bus_rdata_o,
    // Serial clock pin
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    // Serial data pin
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // System
    output logic pins_claimed_o,
    output logic irq_o
);
    import i2c_slave_pkg::*;

    // ==================================================================
    // Register decode
    function automatic logic hit(input logic strobe, input logic [3:0] addr,
                                 input logic [3:0] offset);
        hit = strobe && (addr == offset);
    endfunction

    wire wr_ctrl = hit(bus_req_i.write, bus_req_i.addr, CTRL_OFFSET);
    wire wr_own = hit(bus_req_i.write, bus_req_i.addr, OWN_ADDR_OFFSET);
    wire wr_data = hit(bus_req_i.write, bus_req_i.addr, DATA_OFFSET);
    wire rd_data = hit(bus_req_i.read, bus_req_i.addr, DATA_OFFSET);
    wire rd_int = hit(bus_req_i.read, bus_req_i.addr, INT_STATUS_OFFSET);
    wire wr_mask = hit(bus_req_i.write, bus_req_i.addr, INT_MASK_OFFSET);
    wire wr_index = hit(bus_req_i.write, bus_req_i.addr, BUF_INDEX_OFFSET);
    wire wr_buf = hit(bus_req_i.write, bus_req_i.addr, BUF_DATA_OFFSET);
    wire rd_buf = hit(bus_req_i.read, bus_req_i.addr, BUF_DATA_OFFSET);

    // ==================================================================
    // Declarations
    ctrl_type ctrl_reg;
    logic [6:0] own_addr_reg;
    logic [7:0] tx_data_reg;
    logic [EV_W-1:0] int_mask_reg;
    logic [EV_W-1:0] int_status_reg;
    logic [EV_W-1:0] int_status_next;
    logic [BUF_PTR_W-1:0] buf_index_reg;
    logic [7:0] buffer_mem [BUF_DEPTH];
    logic [7:0] rdata_next;

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;

    state_type state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic ack_phase_reg;
    logic rw_reg;
    logic first_byte_reg;
    logic sda_drive_reg;
    logic stalled_reg;
    logic stall_tx_reg;
    logic nack_sent_reg;
    logic [3:0] setup_cnt_reg;
    logic [BUF_PTR_W-1:0] ptr_reg;
    logic [7:0] rx_data_reg;
    logic is_addr_reg;
    logic master_ack_reg;
    logic addr_match_reg;
    logic [EV_W-1:0] event_reg;
    logic mst_wr_reg;
    logic [7:0] mst_wr_data_reg;
    logic [BUF_PTR_W-1:0] mst_wr_ptr_reg;

    // ==================================================================
    // Pin synchronisers and bus condition detection
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    // Sampling at 10 MHz resolves every phase of a 400 kHz clock
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s && !scl_prev_reg;
    wire scl_fall = !scl_s && scl_prev_reg;
    wire start_det = scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
    wire stop_det = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

    wire ram_mode = ctrl_reg.ram_buffer_mode;
    wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
    wire addr_ok = !(ctrl_reg.hw_match_en || ram_mode) ||
                   (shift_reg[6:0] == own_addr_reg);
    wire [7:0] buf_mst_rd = buffer_mem[ptr_reg];
    wire [BUF_PTR_W-1:0] ptr_inc = ptr_reg + 5'd1;
    // Firmware service that ends a stall
    wire svc = stalled_reg && (stall_tx_reg ? wr_data : rd_data);

    // ==================================================================
    // Firmware registers
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            ctrl_reg <= ctrl_type'(CTRL_RESET);
            own_addr_reg <= OWN_ADDR_RESET;
            tx_data_reg <= 8'h00;
            int_mask_reg <= INT_MASK_RESET;
            buf_index_reg <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= ctrl_type'(bus_req_i.wdata[4:0]);
            if (wr_own)
                own_addr_reg <= bus_req_i.wdata[6:0];
            if (wr_data)
                tx_data_reg <= bus_req_i.wdata;
            if (wr_mask)
                int_mask_reg <= bus_req_i.wdata[EV_W-1:0];
            if (wr_index)
                buf_index_reg <= bus_req_i.wdata[BUF_PTR_W-1:0];
            else if (wr_buf || rd_buf)
                buf_index_reg <= buf_index_reg + 5'd1;
        end
    end

    // ==================================================================
    // Buffer RAM; a master write in the same cycle wins over firmware
    always_ff @(posedge clock_i)
    begin
        if (mst_wr_reg)
            buffer_mem[mst_wr_ptr_reg] <= mst_wr_data_reg;
        else if (wr_buf)
            buffer_mem[buf_index_reg] <= bus_req_i.wdata;
    end

    // ==================================================================
    // Read data, one cycle after the strobe
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (bus_req_i.addr)
            CTRL_OFFSET: rdata_next = {3'b000, ctrl_reg};
            OWN_ADDR_OFFSET: rdata_next = {1'b0, own_addr_reg};
            DATA_OFFSET: rdata_next = rx_data_reg;
            STATUS_OFFSET: rdata_next = {2'b00, addr_match_reg, master_ack_reg,
                                         is_addr_reg, rw_reg, stalled_reg,
                                         state_reg != ST_IDLE};
            INT_STATUS_OFFSET: rdata_next = {3'b000, int_status_reg};
            INT_MASK_OFFSET: rdata_next = {3'b000, int_mask_reg};
            BUF_INDEX_OFFSET: rdata_next = {3'b000, buf_index_reg};
            BUF_DATA_OFFSET: rdata_next = buffer_mem[buf_index_reg];
            BUF_PTR_OFFSET: rdata_next = {3'b000, ptr_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            bus_rdata_o <= 8'h00;
        else if (bus_req_i.read)
            bus_rdata_o <= rdata_next;
        else
            bus_rdata_o <= 8'h00;
    end

    // ==================================================================
    // Sticky interrupt status; an event beats a clearing read
    always_comb
    begin
        int_status_next = rd_int ? '0 : int_status_reg;
        int_status_next = int_status_next | event_reg;
        int_status_next[EV_START] = int_status_next[EV_START] |
                                    (ctrl_reg.monitor_en && start_det);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            int_status_reg <= '0;
        else
            int_status_reg <= int_status_next;
    end

    assign irq_o = |(int_status_reg & int_mask_reg);

    // ==================================================================
    // Pins
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign pins_claimed_o = ctrl_reg.enable;
    assign scl_oe_n_o = !(ctrl_reg.enable &&
                          (stalled_reg || setup_cnt_reg != 4'h0));
    assign sda_oe_n_o = !(ctrl_reg.enable && sda_drive_reg);

    // ==================================================================
    // Byte engine
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            ack_phase_reg <= 1'b0;
            rw_reg <= 1'b0;
            first_byte_reg <= 1'b0;
            sda_drive_reg <= 1'b0;
            stalled_reg <= 1'b0;
            stall_tx_reg <= 1'b0;
            nack_sent_reg <= 1'b0;
            setup_cnt_reg <= 4'h0;
            ptr_reg <= '0;
            rx_data_reg <= 8'h00;
            is_addr_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            addr_match_reg <= 1'b0;
            event_reg <= '0;
            mst_wr_reg <= 1'b0;
            mst_wr_data_reg <= 8'h00;
            mst_wr_ptr_reg <= '0;
        end
        else
        begin
            event_reg <= '0;
            mst_wr_reg <= 1'b0;
            if (setup_cnt_reg != 4'h0)
                setup_cnt_reg <= setup_cnt_reg - 4'h1;
            if (!ctrl_reg.enable)
            begin
                state_reg <= ST_IDLE;
                sda_drive_reg <= 1'b0;
                stalled_reg <= 1'b0;
                addr_match_reg <= 1'b0;
            end
            else if (start_det)
            begin
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 3'h0;
                sda_drive_reg <= 1'b0;
                stalled_reg <= 1'b0;
                is_addr_reg <= 1'b1;
                addr_match_reg <= 1'b0;
            end
            else if (stop_det)
            begin
                if (addr_match_reg)
                    event_reg[EV_STOP] <= 1'b1;
                state_reg <= ST_IDLE;
                sda_drive_reg <= 1'b0;
                stalled_reg <= 1'b0;
                addr_match_reg <= 1'b0;
            end
            else
            begin
                unique case (state_reg)
                    ST_IDLE:
                    begin
                        sda_drive_reg <= 1'b0;
                    end
                    ST_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7)
                            begin
                                if (!addr_ok)
                                    state_reg <= ST_IDLE;
                                else
                                begin
                                    rw_reg <= sda_s;
                                    stall_tx_reg <= sda_s;
                                    rx_data_reg <= rx_byte;
                                    addr_match_reg <= 1'b1;
                                    first_byte_reg <= 1'b1;
                                    ack_phase_reg <= 1'b0;
                                    state_reg <= ST_ACK_OUT;
                                end
                            end
                        end
                    end
                    ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7)
                            begin
                                is_addr_reg <= 1'b0;
                                stall_tx_reg <= 1'b0;
                                ack_phase_reg <= 1'b0;
                                state_reg <= ST_ACK_OUT;
                                if (!ram_mode)
                                    rx_data_reg <= rx_byte;
                                else if (first_byte_reg)
                                begin
                                    ptr_reg <= rx_byte[BUF_PTR_W-1:0];
                                    first_byte_reg <= 1'b0;
                                end
                                else
                                begin
                                    mst_wr_reg <= 1'b1;
                                    mst_wr_data_reg <= rx_byte;
                                    mst_wr_ptr_reg <= ptr_reg;
                                    ptr_reg <= ptr_inc;
                                end
                            end
                        end
                    end
                    ST_ACK_OUT:
                    begin
                        if (!ack_phase_reg && stalled_reg)
                        begin
                            if (svc)
                            begin
                                stalled_reg <= 1'b0;
                                sda_drive_reg <= !ctrl_reg.nack;
                                nack_sent_reg <= ctrl_reg.nack;
                                setup_cnt_reg <= SETUP_CYCLES;
                                ack_phase_reg <= 1'b1;
                            end
                        end
                        else if (!ack_phase_reg && scl_fall)
                        begin
                            if (!ram_mode)
                            begin
                                stalled_reg <= 1'b1;
                                event_reg[EV_ADDR] <= is_addr_reg;
                                event_reg[EV_RX] <= !is_addr_reg;
                                event_reg[EV_TX] <= stall_tx_reg;
                            end
                            else
                            begin
                                sda_drive_reg <= 1'b1;
                                nack_sent_reg <= 1'b0;
                                ack_phase_reg <= 1'b1;
                            end
                        end
                        else if (ack_phase_reg && scl_fall)
                        begin
                            bit_cnt_reg <= 3'h0;
                            if (nack_sent_reg)
                            begin
                                sda_drive_reg <= 1'b0;
                                state_reg <= ST_IDLE;
                            end
                            else if (rw_reg)
                            begin
                                shift_reg <= ram_mode ? buf_mst_rd : tx_data_reg;
                                sda_drive_reg <= ram_mode ? !buf_mst_rd[7] :
                                                 !tx_data_reg[7];
                                if (ram_mode)
                                    ptr_reg <= ptr_inc;
                                state_reg <= ST_TX;
                            end
                            else
                            begin
                                sda_drive_reg <= 1'b0;
                                state_reg <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_rise)
                        begin
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == 3'h7)
                            begin
                                ack_phase_reg <= 1'b0;
                                state_reg <= ST_ACK_IN;
                            end
                        end
                        else if (scl_fall)
                        begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_drive_reg <= !shift_reg[6];
                        end
                    end
                    ST_ACK_IN:
                    begin
                        if (stalled_reg)
                        begin
                            if (svc)
                            begin
                                stalled_reg <= 1'b0;
                                shift_reg <= bus_req_i.wdata;
                                sda_drive_reg <= !bus_req_i.wdata[7];
                                setup_cnt_reg <= SETUP_CYCLES;
                                bit_cnt_reg <= 3'h0;
                                state_reg <= ST_TX;
                            end
                        end
                        else if (!ack_phase_reg && scl_fall)
                        begin
                            sda_drive_reg <= 1'b0;
                            ack_phase_reg <= 1'b1;
                        end
                        else if (ack_phase_reg && scl_rise)
                            master_ack_reg <= !sda_s;
                        else if (ack_phase_reg && scl_fall)
                        begin
                            bit_cnt_reg <= 3'h0;
                            if (!master_ack_reg)
                                state_reg <= ST_IDLE;
                            else if (ram_mode)
                            begin
                                shift_reg <= buf_mst_rd;
                                sda_drive_reg <= !buf_mst_rd[7];
                                ptr_reg <= ptr_inc;
                                state_reg <= ST_TX;
                            end
                            else
                            begin
                                stalled_reg <= 1'b1;
                                stall_tx_reg <= 1'b1;
                                event_reg[EV_TX] <= 1'b1;
                            end
                        end
                    end
                    default:
                    begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ==== tb/i2c_slave_assertions.sv ====
// Port checker of the serial slave
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_checker
(
    // Watched ports
    input wire logic clock_i, reset_i, scl_i, scl_oe_n_o, sda_i,
    input wire logic sda_oe_n_o, pins_claimed_o, irq_o,
    input wire i2c_slave_pkg::reg_req_type bus_req_i,
    input wire logic [7:0] bus_rdata_o
);
    import i2c_slave_pkg::*;
    logic ram_reg;
    logic mask_reg;
    wire ctrl_wr = bus_req_i.write && bus_req_i.addr == CTRL_OFFSET;
    wire mask_wr = bus_req_i.write && bus_req_i.addr == INT_MASK_OFFSET;
    wire data_acc = (bus_req_i.write | bus_req_i.read) && bus_req_i.addr == DATA_OFFSET;
    always_ff @(posedge clock_i)
        ram_reg <= !reset_i && (ctrl_wr ? bus_req_i.wdata[2] : ram_reg);
    always_ff @(posedge clock_i)
        mask_reg <= !reset_i && (mask_wr ? |bus_req_i.wdata[4:0] : mask_reg);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_rdata_idle: assert property (!$past(bus_req_i.read) |-> bus_rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_irq_masked: assert property (!mask_reg && !$past(mask_reg) |-> !irq_o)
        else $error("interrupt with empty mask");
    a_pins_idle: assert property (!pins_claimed_o |-> scl_oe_n_o && sda_oe_n_o)
        else $error("pin driven while disabled");
    a_claim_cause: assert property ($changed(pins_claimed_o) |-> $past(ctrl_wr))
        else $error("pin claim changed without control write");
    a_drive_low: assert property ((scl_oe_n_o || !scl_i) && (sda_oe_n_o || !sda_i))
        else $error("driven pin not low");
    a_stall_start: assert property ($fell(scl_oe_n_o) |-> !$past(scl_i))
        else $error("stall began while clock high");
    a_stall_release: assert property ($rose(scl_oe_n_o) |->
        $past(data_acc, 4) || $past(data_acc, 5) || $past(data_acc, 6))
        else $error("stall released without service");
    a_ram_nostall: assert property (ram_reg |-> scl_oe_n_o)
        else $error("clock held in buffer mode");
endmodule
bind i2c_slave_enhanced i2c_slave_checker i2c_slave_checker_i (.clock_i, .reset_i,
    .bus_req_i, .bus_rdata_o, .scl_i, .scl_oe_n_o, .sda_i, .sda_oe_n_o,
    .pins_claimed_o, .irq_o);
`default_nettype wire

// ==== tb/master_model.sv ====
// Two-wire bus master model with clock stretch handling
`timescale 1ns/1ns
`default_nettype none
module master_model
(
    // Wire levels
    input wire logic scl_i, sda_i,
    // Open drain drive, 1 releases
    output logic scl_o, sda_o, hung_o
);
    initial {scl_o, sda_o, hung_o} = 3'b110;
    // Release clock, bounded wait while held low
    task automatic rise();
        scl_o = 1'b1;
        for (int n = 0; n < 3000 && scl_i !== 1'b1; n++) #100;
        if (scl_i !== 1'b1) hung_o = 1'b1;
    endtask
    // Start when a is 1, stop when a is 0
    task automatic frame(input logic a);
        #200 sda_o = a;
        #200 rise();
        #400 sda_o = ~a;
        #400 scl_o = ~a;
    endtask
    // Nine clocks, MSB first, last is acknowledge
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            #200 sda_o = tx[i];
            #200 rise();
            #200 rx[i] = sda_i;
            #200 scl_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/i2c_slave_enhanced_bench.sv ====
// Self-checking bench of the serial slave
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_enhanced_bench;
    import i2c_slave_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    reg_req_type bus_req_i = '0;
    logic [7:0] bus_rdata_o;
    logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, pins_claimed_o, irq_o, m_scl, m_sda, hung;
    wire scl_w = m_scl & (scl_oe_n_o | scl_o);
    wire sda_w = m_sda & (sda_oe_n_o | sda_o);
    int bad_count = 0;
    int checks = 0;
    logic [8:0] r;
    always #50 clock_i = ~clock_i;
    i2c_slave_enhanced i2c_slave_enhanced_i (.clock_i, .reset_i, .bus_req_i, .bus_rdata_o,
        .scl_i(scl_w), .scl_o, .scl_oe_n_o, .sda_i(sda_w), .sda_o, .sda_oe_n_o,
        .pins_claimed_o, .irq_o);
    master_model master_model_i (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl),
        .sda_o(m_sda), .hung_o(hung));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_i) bus_req_i <= '{a, v, 1'b1, 1'b0};
        @(posedge clock_i) bus_req_i <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_i) bus_req_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i) bus_req_i <= '0;
        @(negedge clock_i) check({1'b0, bus_rdata_o}, {1'b0, e});
    endtask
    // Firmware service of one stalled byte
    task automatic serve(input logic [7:0] e, input logic [7:0] ev);
        for (int n = 0; n < 4000 && irq_o !== 1'b1; n++) @(posedge clock_i);
        check({8'h00, irq_o}, 9'h001);
        rd(INT_STATUS_OFFSET, ev);
        rd(DATA_OFFSET, e);
    endtask
    task automatic legacy_write();
        wr(OWN_ADDR_OFFSET, 8'h2A);
        wr(INT_MASK_OFFSET, 8'h03);
        wr(CTRL_OFFSET, 8'h03);
        @(negedge clock_i) check({8'h00, pins_claimed_o}, 9'h001);
        fork
            begin
                master_model_i.frame(1'b1);
                master_model_i.xfer({8'h54, 1'b1}, r);
                check({8'h00, r[0]}, 9'h000);
                master_model_i.xfer({8'hA5, 1'b1}, r);
                check({8'h00, r[0]}, 9'h000);
                master_model_i.frame(1'b0);
            end
            begin
                serve(8'h54, 8'h01);
                serve(8'hA5, 8'h02);
            end
        join
    endtask
    task automatic foreign_address();
        master_model_i.frame(1'b1);
        master_model_i.xfer({8'h56, 1'b1}, r);
        check({8'h00, r[0]}, 9'h001);
        master_model_i.frame(1'b0);
        check({8'h00, irq_o}, 9'h000);
    endtask
    task automatic legacy_read();
        fork
            begin
                master_model_i.frame(1'b1);
                master_model_i.xfer({8'h55, 1'b1}, r);
                check({8'h00, r[0]}, 9'h000);
                master_model_i.xfer(9'h1FF, r);
                check(r, {8'hC3, 1'b1});
                master_model_i.frame(1'b0);
            end
            begin
                for (int n = 0; n < 4000 && irq_o !== 1'b1; n++) @(posedge clock_i);
                rd(INT_STATUS_OFFSET, 8'h0D);
                wr(DATA_OFFSET, 8'hC3);
            end
        join
    endtask
    task automatic monitor();
        wr(CTRL_OFFSET, 8'h08);
        wr(INT_MASK_OFFSET, 8'h10);
        @(negedge clock_i) check({8'h00, pins_claimed_o}, 9'h000);
        master_model_i.frame(1'b1);
        master_model_i.frame(1'b0);
        check({8'h00, irq_o}, 9'h001);
        rd(INT_STATUS_OFFSET, 8'h10);
    endtask
    task automatic buffered();
        wr(CTRL_OFFSET, 8'h07);
        wr(BUF_INDEX_OFFSET, 8'h04);
        wr(BUF_DATA_OFFSET, 8'h3C);
        master_model_i.frame(1'b1);
        master_model_i.xfer({8'h54, 1'b1}, r);
        master_model_i.xfer({8'h03, 1'b1}, r);
        master_model_i.xfer({8'h77, 1'b1}, r);
        check({8'h00, r[0]}, 9'h000);
        master_model_i.frame(1'b1);
        master_model_i.xfer({8'h55, 1'b1}, r);
        master_model_i.xfer(9'h1FF, r);
        check(r, {8'h3C, 1'b1});
        master_model_i.frame(1'b0);
        wr(BUF_INDEX_OFFSET, 8'h03);
        rd(BUF_DATA_OFFSET, 8'h77);
        rd(BUF_PTR_OFFSET, 8'h05);
        check({8'h00, irq_o}, 9'h000);
        rd(INT_STATUS_OFFSET, 8'h08);
    endtask
    initial
    begin
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(CTRL_OFFSET, 8'h00);
        rd(4'hF, 8'h00);
        legacy_write();
        foreign_address();
        legacy_read();
        buffered();
        monitor();
        check({8'h00, hung}, 9'h000);
        complete_run();
    end
    initial
    begin
        #9000000;
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
